// [design/spms_pkg.sv]
/*
 * constants, register map and field layout of the sector protection mode select block.
 * assumes one 40 MHz clock and an AHB-Lite master issuing single word transfers.
 */
package spms_pkg;

	// ----------------------------------------------------------------
	// register byte addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] SPMS_ADDR_MODE      = 8'h00;
	localparam logic [7:0] SPMS_ADDR_CFG1      = 8'h04;
	localparam logic [7:0] SPMS_ADDR_CFG3      = 8'h08;
	localparam logic [7:0] SPMS_ADDR_PWD_LO    = 8'h0c;
	localparam logic [7:0] SPMS_ADDR_PWD_HI    = 8'h10;
	localparam logic [7:0] SPMS_ADDR_UNLOCK_LO = 8'h14;
	localparam logic [7:0] SPMS_ADDR_UNLOCK_HI = 8'h18;
	localparam logic [7:0] SPMS_ADDR_FREEZE    = 8'h1c;
	localparam logic [7:0] SPMS_ADDR_LOCKS     = 8'h20;
	localparam logic [7:0] SPMS_ADDR_ERASE     = 8'h24;
	localparam logic [7:0] SPMS_ADDR_STATUS    = 8'h28;

	// ----------------------------------------------------------------
	// field positions and masks
	// ----------------------------------------------------------------
	localparam int SPMS_BIT_PERMANENT = 0;
	localparam int SPMS_BIT_PERSIST   = 1;
	localparam int SPMS_BIT_PASSWORD  = 2;
	localparam int SPMS_BIT_READ_PWD  = 5;
	localparam int SPMS_BIT_TOP_BOT   = 5;
	localparam int SPMS_BIT_FREEZE    = 0;

	localparam logic [15:0] SPMS_MODE_RSVD_MASK = 16'hffc0;
	localparam logic [7:0]  SPMS_CFG1_PWD_MASK  = 8'hfc;
	localparam logic [7:0]  SPMS_CFG1_PER_MASK  = 8'h74;
	localparam logic [7:0]  SPMS_CFG3_PER_MASK  = 8'h08;

	// ----------------------------------------------------------------
	// factory and reset values
	// ----------------------------------------------------------------
	localparam logic [15:0] SPMS_MODE_FACTORY = 16'hffff;
	localparam logic [7:0]  SPMS_CFG_FACTORY  = 8'h00;
	localparam logic [63:0] SPMS_PWD_FACTORY  = 64'hffff_ffff_ffff_ffff;
	localparam logic [31:0] SPMS_ALL_ONES     = 32'hffff_ffff;

	localparam logic [1:0] SPMS_HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] SPMS_HSIZE_WORD    = 3'h2;

endpackage

// [design/spms_mode_gate.sv]
/*
 * decodes the mode selectors into the write and read permissions of the block.
 * assumes the inputs are registered state of the parent.
 */
`timescale 1ns/1ps
module spms_mode_gate
	import spms_pkg::*;
(
	input  wire logic [15:0] mode,
	input  wire logic [7:0]  cfg1,
	input  wire logic        freeze,
	input  wire logic        unlocked,
	output logic             lock_bits_ok,
	output logic             mode_reg_ok,
	output logic             pwd_reg_ok,
	output logic             full_lock,
	output logic [7:0]       cfg1_ok_mask,
	output logic [7:0]       cfg3_ok_mask,
	output logic             top_bottom
);
	logic pwd_on;
	logic per_on;
	logic prm_on;
	logic rdp_on;

	always_comb
	begin
		pwd_on = ~mode[SPMS_BIT_PASSWORD];
		per_on = ~mode[SPMS_BIT_PERSIST];
		prm_on = ~mode[SPMS_BIT_PERMANENT];
		rdp_on = ~mode[SPMS_BIT_READ_PWD];
		full_lock = pwd_on & rdp_on & ~unlocked;
		lock_bits_ok = ~prm_on & freeze & ~(pwd_on & ~unlocked) & ~full_lock;
		mode_reg_ok = ~pwd_on & ~per_on & ~full_lock;
		pwd_reg_ok = ~pwd_on;
		cfg1_ok_mask = ~((pwd_on ? SPMS_CFG1_PWD_MASK : 8'h00)
			| (per_on ? SPMS_CFG1_PER_MASK : 8'h00)
			| (full_lock ? 8'hff : 8'h00));
		cfg3_ok_mask = ~((per_on ? SPMS_CFG3_PER_MASK : 8'h00)
			| (full_lock ? 8'hff : 8'h00));
		top_bottom = cfg1[SPMS_BIT_TOP_BOT];
	end
endmodule

// [design/spms_top.sv]
/*
 * sector protection mode select: nonvolatile mode register, config copies, password,
 * sector lock bits and freeze bit behind an AHB-Lite slave.
 * assumes POWER_ON_RESET stands for power-up of the nonvolatile cells and RESET for
 * a hardware reset; both synchronous to REF_CLK.
 */
`timescale 1ns/1ps
module spms_top
	import spms_pkg::*;
#(
	parameter int NUM_SECTORS = 32
)
(
	input  wire logic                           REF_CLK,
	input  wire logic                           RESET,
	input  wire logic                           POWER_ON_RESET,
	input  wire logic                           HSEL,
	input  wire logic [31:0]                    HADDR,
	input  wire logic [1:0]                     HTRANS,
	input  wire logic                           HWRITE,
	input  wire logic [2:0]                     HSIZE,
	input  wire logic [31:0]                    HWDATA,
	input  wire logic                           HREADY,
	output logic [31:0]                         HRDATA,
	output logic                                HREADYOUT,
	output logic                                HRESP,
	input  wire logic [$clog2(NUM_SECTORS)-1:0] READ_SECTOR,
	output logic                                READ_ALLOW,
	output logic                                MEM_PROGRAM_BLOCK,
	output logic                                LOCK_BITS_WRITABLE,
	output logic [NUM_SECTORS-1:0]              SECTOR_LOCK
);
	import spms_pkg::*;

	// ----------------------------------------------------------------
	// parameter check
	// ----------------------------------------------------------------
	// the lock bits travel as one bus word, so more sectors would need a wider map
	if (NUM_SECTORS < 2 || NUM_SECTORS > 32)
	begin : g_bad_sectors
		$error("NUM_SECTORS must lie between 2 and 32");
	end

	localparam int                     SECTOR_BITS = $clog2(NUM_SECTORS);
	localparam logic [SECTOR_BITS-1:0] TOP_SECTOR  = SECTOR_BITS'(NUM_SECTORS - 1);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [15:0]            mode_reg,      mode_next;
	logic [7:0]             cfg1_reg,      cfg1_next;
	logic [7:0]             cfg3_reg,      cfg3_next;
	logic [63:0]            pwd_reg,       pwd_next;
	logic [NUM_SECTORS-1:0] locks_reg,     locks_next;
	logic [31:0]            try_lo_reg,    try_lo_next;
	logic                   unlocked_reg,  unlocked_next;
	logic                   freeze_reg,    freeze_next;
	logic                   dsel_reg,      dsel_next;
	logic                   dwr_reg,       dwr_next;
	logic [7:0]             daddr_reg,     daddr_next;
	logic [31:0]            rdata_reg,     rdata_next;

	logic       lock_bits_ok;
	logic       mode_reg_ok;
	logic       pwd_reg_ok;
	logic       full_lock;
	logic [7:0] cfg1_ok_mask;
	logic [7:0] cfg3_ok_mask;
	logic       top_bottom;
	logic       wr;
	logic       addr_phase;
	logic [31:0] status;

	spms_mode_gate spms_mode_gate_inst
	(
		.mode         (mode_reg),
		.cfg1         (cfg1_reg),
		.freeze       (freeze_reg),
		.unlocked     (unlocked_reg),
		.lock_bits_ok (lock_bits_ok),
		.mode_reg_ok  (mode_reg_ok),
		.pwd_reg_ok   (pwd_reg_ok),
		.full_lock    (full_lock),
		.cfg1_ok_mask (cfg1_ok_mask),
		.cfg3_ok_mask (cfg3_ok_mask),
		.top_bottom   (top_bottom)
	);

	// ----------------------------------------------------------------
	// bus phases
	// ----------------------------------------------------------------
	always_comb
	begin
		addr_phase = HSEL & HREADY & HTRANS[1];
		wr = dsel_reg & dwr_reg;
		dsel_next = addr_phase;
		dwr_next = addr_phase & HWRITE;
		daddr_next = addr_phase ? HADDR[7:0] : daddr_reg;
	end

	// ----------------------------------------------------------------
	// register updates
	// ----------------------------------------------------------------
	always_comb
	begin
		mode_next = mode_reg;
		cfg1_next = cfg1_reg;
		cfg3_next = cfg3_reg;
		pwd_next = pwd_reg;
		locks_next = locks_reg;
		try_lo_next = try_lo_reg;
		unlocked_next = unlocked_reg;
		freeze_next = freeze_reg;
		if (wr)
		begin
			if (daddr_reg == SPMS_ADDR_MODE)
			begin
				// nonvolatile cells program only toward zero
				if (mode_reg_ok)
					mode_next = (mode_reg & HWDATA[15:0]) | SPMS_MODE_RSVD_MASK;
			end
			else if (daddr_reg == SPMS_ADDR_CFG1)
			begin
				cfg1_next = (cfg1_reg & ~cfg1_ok_mask) | (HWDATA[7:0] & cfg1_ok_mask);
			end
			else if (daddr_reg == SPMS_ADDR_CFG3)
			begin
				cfg3_next = (cfg3_reg & ~cfg3_ok_mask) | (HWDATA[7:0] & cfg3_ok_mask);
			end
			else if (daddr_reg == SPMS_ADDR_PWD_LO)
			begin
				if (pwd_reg_ok)
					pwd_next[31:0] = HWDATA;
			end
			else if (daddr_reg == SPMS_ADDR_PWD_HI)
			begin
				if (pwd_reg_ok)
					pwd_next[63:32] = HWDATA;
			end
			else if (daddr_reg == SPMS_ADDR_UNLOCK_LO)
			begin
				try_lo_next = HWDATA;
			end
			else if (daddr_reg == SPMS_ADDR_UNLOCK_HI)
			begin
				// correct password opens lock bits and reopens freeze
				if ({HWDATA, try_lo_reg} == pwd_reg && ~pwd_reg_ok)
				begin
					unlocked_next = 1'b1;
					freeze_next = 1'b1;
				end
			end
			else if (daddr_reg == SPMS_ADDR_FREEZE)
			begin
				// writes here can only drop freeze; of the software writes, only a correct password unlock raises it
				if (~HWDATA[SPMS_BIT_FREEZE])
					freeze_next = 1'b0;
			end
			else if (daddr_reg == SPMS_ADDR_LOCKS)
			begin
				// program clears lock bits only when allowed
				if (lock_bits_ok)
					locks_next = locks_reg & HWDATA[NUM_SECTORS-1:0];
			end
			else if (daddr_reg == SPMS_ADDR_ERASE)
			begin
				if (lock_bits_ok)
					locks_next = SPMS_ALL_ONES[NUM_SECTORS-1:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// read data, taken from next values so a write just before is seen; status bits 2 and 3 and the password read gate use current state
	// ----------------------------------------------------------------
	always_comb
	begin
		status = 32'h0000_0000;
		status[0] = unlocked_next;
		status[1] = freeze_next;
		status[2] = lock_bits_ok;
		status[3] = full_lock;
		rdata_next = 32'h0000_0000;
		if (addr_phase && !HWRITE)
		begin
			if (HADDR[7:0] == SPMS_ADDR_MODE)
				rdata_next = {16'h0000, mode_next};
			else if (HADDR[7:0] == SPMS_ADDR_CFG1)
				rdata_next = {24'h000000, cfg1_next};
			else if (HADDR[7:0] == SPMS_ADDR_CFG3)
				rdata_next = {24'h000000, cfg3_next};
			// password reads give no information while password mode holds
			else if (HADDR[7:0] == SPMS_ADDR_PWD_LO)
				rdata_next = pwd_reg_ok ? pwd_next[31:0] : SPMS_ALL_ONES;
			else if (HADDR[7:0] == SPMS_ADDR_PWD_HI)
				rdata_next = pwd_reg_ok ? pwd_next[63:32] : SPMS_ALL_ONES;
			else if (HADDR[7:0] == SPMS_ADDR_FREEZE)
				rdata_next = {31'h00000000, freeze_next};
			else if (HADDR[7:0] == SPMS_ADDR_LOCKS)
				rdata_next = 32'(locks_next);
			else if (HADDR[7:0] == SPMS_ADDR_STATUS)
				rdata_next = status;
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge REF_CLK)
	begin
		// only power-up restores the nonvolatile cells
		if (POWER_ON_RESET)
		begin
			mode_reg <= SPMS_MODE_FACTORY;
			cfg1_reg <= SPMS_CFG_FACTORY;
			cfg3_reg <= SPMS_CFG_FACTORY;
			pwd_reg <= SPMS_PWD_FACTORY;
			locks_reg <= SPMS_ALL_ONES[NUM_SECTORS-1:0];
		end
		else
		begin
			mode_reg <= mode_next;
			cfg1_reg <= cfg1_next;
			cfg3_reg <= cfg3_next;
			pwd_reg <= pwd_next;
			locks_reg <= locks_next;
		end
		if (POWER_ON_RESET || RESET)
		begin
			try_lo_reg <= 32'h0000_0000;
			unlocked_reg <= 1'b0;
			// freeze starts closed when password mode is selected
			freeze_reg <= POWER_ON_RESET ? 1'b1 : mode_reg[SPMS_BIT_PASSWORD];
			dsel_reg <= 1'b0;
			dwr_reg <= 1'b0;
			daddr_reg <= 8'h00;
			rdata_reg <= 32'h0000_0000;
		end
		else
		begin
			try_lo_reg <= try_lo_next;
			unlocked_reg <= unlocked_next;
			freeze_reg <= freeze_next;
			dsel_reg <= dsel_next;
			dwr_reg <= dwr_next;
			daddr_reg <= daddr_next;
			rdata_reg <= rdata_next;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	always_comb
	begin
		HRDATA = rdata_reg;
		HREADYOUT = 1'b1;
		HRESP = 1'b0;
		SECTOR_LOCK = locks_reg;
		LOCK_BITS_WRITABLE = lock_bits_ok;
		MEM_PROGRAM_BLOCK = full_lock;
		READ_ALLOW = ~full_lock | (READ_SECTOR == (top_bottom ? '0 : TOP_SECTOR));
	end
endmodule

// [dv/spms_asserts.sv]
/*
 * port assertions of the sector protection mode select block.
 * assumes it is bound to spms_top and sees only that module's ports.
 */
`timescale 1ns/1ps
module spms_asserts
#(
	parameter int NUM_SECTORS = 32
)
(
	input wire logic                           REF_CLK,
	input wire logic                           RESET,
	input wire logic                           POWER_ON_RESET,
	input wire logic                           HSEL,
	input wire logic [1:0]                     HTRANS,
	input wire logic                           HWRITE,
	input wire logic                           HREADY,
	input wire logic [31:0]                    HRDATA,
	input wire logic                           HREADYOUT,
	input wire logic                           HRESP,
	input wire logic [$clog2(NUM_SECTORS)-1:0] READ_SECTOR,
	input wire logic                           READ_ALLOW,
	input wire logic                           MEM_PROGRAM_BLOCK,
	input wire logic                           LOCK_BITS_WRITABLE,
	input wire logic [NUM_SECTORS-1:0]         SECTOR_LOCK
);
	logic wr_reg;
	logic wr_next;

	default clocking @(posedge REF_CLK); endclocking
	default disable iff (RESET || POWER_ON_RESET);

	// remembers a write address phase so a data-phase update can be traced back
	always_comb wr_next = HSEL & HREADY & HTRANS[1] & HWRITE;
	always_ff @(posedge REF_CLK) wr_reg <= wr_next;

	a_ready_high: assert property (HREADYOUT) else $error("wait state inserted");
	a_resp_okay: assert property (!HRESP) else $error("error response seen");
	a_rdata_idle: assert property (!$past(HSEL && HREADY && HTRANS[1] && !HWRITE)
		|-> HRDATA == 32'h0) else $error("read data outside data phase");
	a_lock_guard: assert property ((SECTOR_LOCK != $past(SECTOR_LOCK))
		&& !$past(POWER_ON_RESET) |-> $past(LOCK_BITS_WRITABLE))
		else $error("lock bits changed while protected");
	a_block_nolock: assert property (MEM_PROGRAM_BLOCK |-> !LOCK_BITS_WRITABLE)
		else $error("lock bits writable under full lock");
	a_read_open: assert property (!MEM_PROGRAM_BLOCK |-> READ_ALLOW)
		else $error("read refused without full lock");
	a_read_boot: assert property (MEM_PROGRAM_BLOCK && READ_ALLOW
		|-> READ_SECTOR == 0 || READ_SECTOR == NUM_SECTORS - 1)
		else $error("non boot sector readable under full lock");
	a_por_factory: assert property ($fell(POWER_ON_RESET) |-> SECTOR_LOCK == '1
		&& LOCK_BITS_WRITABLE && !MEM_PROGRAM_BLOCK) else $error("factory state wrong");
	a_block_cause: assert property ($rose(MEM_PROGRAM_BLOCK)
		|-> $past(wr_reg) || $past(RESET)) else $error("full lock without cause");
endmodule

bind spms_top spms_asserts #(.NUM_SECTORS(NUM_SECTORS)) spms_asserts_inst (
	.REF_CLK(REF_CLK), .RESET(RESET), .POWER_ON_RESET(POWER_ON_RESET), .HSEL(HSEL),
	.HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HRDATA(HRDATA),
	.HREADYOUT(HREADYOUT), .HRESP(HRESP), .READ_SECTOR(READ_SECTOR),
	.READ_ALLOW(READ_ALLOW), .MEM_PROGRAM_BLOCK(MEM_PROGRAM_BLOCK),
	.LOCK_BITS_WRITABLE(LOCK_BITS_WRITABLE), .SECTOR_LOCK(SECTOR_LOCK));

// [dv/spms_host.sv]
/*
 * host model on the register bus: single aligned word transfers.
 * assumes any number of wait states; only the bench watchdog ends a hang.
 */
`timescale 1ns/1ps
module spms_host
	import spms_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata,
	output logic             hsel,
	output logic [31:0]      haddr,
	output logic [1:0]       htrans,
	output logic             hwrite,
	output logic [2:0]       hsize,
	output logic [31:0]      hwdata
);
	initial
	begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = SPMS_HSIZE_WORD;
		hwdata = 32'h0;
	end

	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= SPMS_HTRANS_NONSEQ;
		hwdata <= ~hwdata;
		do @(posedge clk); while (hready !== 1'b1);
		// released address lines must not keep showing the old value
		hsel <= 1'b0;
		htrans <= 2'h0;
		haddr <= ~haddr;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		q = hrdata;
	endtask
endmodule

// [dv/sector_protection_mode_select_tb.sv]
/*
 * self-checking bench of the sector protection mode select block.
 * assumes the host model drives the bus and the checker binds itself.
 */
`timescale 1ns/1ps
module sector_protection_mode_select_tb;
	import spms_pkg::*;
	logic ref_clk, reset, por, hsel, hwrite, hready, hresp, read_allow, mem_block, lock_wr;
	logic [31:0] haddr, hwdata, hrdata, sector_lock, q;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [4:0] read_sector;
	int miscompares, checks_done;

	spms_host spms_host_inst (.clk(ref_clk), .hready(hready), .hrdata(hrdata), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
	spms_top spms_top_inst (.REF_CLK(ref_clk), .RESET(reset), .POWER_ON_RESET(por),
		.HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize),
		.HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready),
		.HRESP(hresp), .READ_SECTOR(read_sector), .READ_ALLOW(read_allow),
		.MEM_PROGRAM_BLOCK(mem_block), .LOCK_BITS_WRITABLE(lock_wr),
		.SECTOR_LOCK(sector_lock));

	task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk1(input logic got, input logic exp);
		checks_done++;
		if (got !== exp)
		begin
			miscompares++;
			$display("wrong value at %0t: flag %b expected %b", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		spms_host_inst.xfer(1'b1, a, d, q);
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		spms_host_inst.xfer(1'b0, a, 32'h0, q);
		chk32(q, e);
	endtask
	task automatic pulse(input logic power);
		if (power) por <= 1'b1;
		else reset <= 1'b1;
		@(posedge ref_clk);
		por <= 1'b0;
		reset <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial
	begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	// the whole sequence needs well under a thousand cycles
	initial
	begin
		repeat (5000) @(posedge ref_clk);
		miscompares++;
		results();
	end

	// ----------------------------------------------------------------
	// test sequence
	// ----------------------------------------------------------------
	initial
	begin
		reset = 1'b1;
		por = 1'b1;
		read_sector = 5'd0;
		miscompares = 0;
		checks_done = 0;
		repeat (4) @(posedge ref_clk);
		reset <= 1'b0;
		por <= 1'b0;
		@(posedge ref_clk);
		rc(SPMS_ADDR_MODE, 32'h0000_ffff);
		rc(SPMS_ADDR_STATUS, 32'h6);
		chk1(lock_wr, 1'b1);
		$display("test factory done");
		wr(SPMS_ADDR_LOCKS, 32'hffff_fff0);
		wr(SPMS_ADDR_FREEZE, 32'h0);
		wr(SPMS_ADDR_LOCKS, 32'h0);
		rc(SPMS_ADDR_LOCKS, 32'hffff_fff0);
		pulse(1'b0);
		wr(SPMS_ADDR_LOCKS, 32'hffff_ff00);
		rc(SPMS_ADDR_LOCKS, 32'hffff_ff00);
		chk32(sector_lock, 32'hffff_ff00);
		$display("test freeze done");
		wr(SPMS_ADDR_MODE, 32'h0000_fffe);
		wr(SPMS_ADDR_ERASE, 32'h0);
		wr(SPMS_ADDR_LOCKS, 32'h0);
		rc(SPMS_ADDR_LOCKS, 32'hffff_ff00);
		rc(SPMS_ADDR_STATUS, 32'h2);
		chk1(lock_wr, 1'b0);
		chk32(sector_lock, 32'hffff_ff00);
		$display("test permanent done");
		wr(SPMS_ADDR_CFG1, 32'hff);
		wr(SPMS_ADDR_MODE, 32'h0000_fffd);
		wr(SPMS_ADDR_CFG1, 32'h0);
		wr(SPMS_ADDR_CFG3, 32'hff);
		wr(SPMS_ADDR_MODE, 32'h0);
		rc(SPMS_ADDR_MODE, 32'h0000_fffc);
		rc(SPMS_ADDR_CFG1, 32'h74);
		rc(SPMS_ADDR_CFG3, 32'hf7);
		$display("test persistent done");
		pulse(1'b1);
		wr(SPMS_ADDR_PWD_LO, 32'h1234_5678);
		wr(SPMS_ADDR_PWD_HI, 32'h9abc_def0);
		wr(SPMS_ADDR_MODE, 32'h0000_ffdb);
		wr(SPMS_ADDR_MODE, 32'h0);
		wr(SPMS_ADDR_CFG1, 32'hff);
		wr(SPMS_ADDR_LOCKS, 32'h0);
		rc(SPMS_ADDR_MODE, 32'h0000_ffdb);
		rc(SPMS_ADDR_CFG1, 32'h0);
		rc(SPMS_ADDR_PWD_LO, 32'hffff_ffff);
		rc(SPMS_ADDR_LOCKS, 32'hffff_ffff);
		rc(SPMS_ADDR_STATUS, 32'ha);
		chk1(mem_block, 1'b1);
		chk1(lock_wr, 1'b0);
		read_sector <= 5'd31;
		@(posedge ref_clk);
		chk1(read_allow, 1'b1);
		read_sector <= 5'd0;
		@(posedge ref_clk);
		chk1(read_allow, 1'b0);
		wr(SPMS_ADDR_UNLOCK_LO, 32'h0);
		wr(SPMS_ADDR_UNLOCK_HI, 32'h0);
		rc(SPMS_ADDR_STATUS, 32'ha);
		wr(SPMS_ADDR_UNLOCK_LO, 32'h1234_5678);
		wr(SPMS_ADDR_UNLOCK_HI, 32'h9abc_def0);
		rc(SPMS_ADDR_STATUS, 32'h7);
		chk1(read_allow, 1'b1);
		chk1(lock_wr, 1'b1);
		wr(SPMS_ADDR_LOCKS, 32'hffff_fffe);
		rc(SPMS_ADDR_LOCKS, 32'hffff_fffe);
		chk32(sector_lock, 32'hffff_fffe);
		pulse(1'b0);
		rc(SPMS_ADDR_STATUS, 32'h8);
		rc(SPMS_ADDR_MODE, 32'h0000_ffdb);
		$display("test password done");
		pulse(1'b1);
		wr(SPMS_ADDR_CFG1, 32'h20);
		wr(SPMS_ADDR_MODE, 32'h0000_ffdb);
		rc(SPMS_ADDR_CFG1, 32'h20);
		rc(SPMS_ADDR_STATUS, 32'ha);
		chk32(sector_lock, 32'hffff_ffff);
		chk1(read_allow, 1'b1);
		read_sector <= 5'd31;
		@(posedge ref_clk);
		chk1(read_allow, 1'b0);
		$display("test bottom boot done");
		results();
	end
endmodule
